//--- dia_contacts.sv
module dia_contacts
(
  input  wire logic       sys_clk_in,
  input  wire logic [7:0] close_in,
  input  wire logic [7:0] pos_in,
  output logic      [7:0] contact_closed_out,
  output logic      [7:0] batt_pos_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts switch on the controller clock
  always_ff @(posedge sys_clk_in)
  begin
    contact_closed_out <= close_in;
    batt_pos_out       <= pos_in;
  end
endmodule

//--- dia_pkg.sv
package dia_pkg;

  typedef enum logic [1:0] {
    DIA_ACT_SHUTDOWN = 2'h0,
    DIA_ACT_LOADDUMP = 2'h1,
    DIA_ACT_WARNING  = 2'h2,
    DIA_ACT_NONE     = 2'h3
  } dia_action_t;

  typedef enum logic [1:0] {
    DIA_SAMP_ALWAYS  = 2'h0,
    DIA_SAMP_HOLDOFF = 2'h1,
    DIA_SAMP_MAINS   = 2'h2,
    DIA_SAMP_NEVER   = 2'h3
  } dia_sampling_t;

endpackage

//--- dia_props.sv
module dia_props
#(
  parameter int NUM_IN = 8
)(
  input wire logic              sys_clk_in,
  input wire logic              rstn_in,
  input wire logic              shutdown_req_out,
  input wire logic              loaddump_req_out,
  input wire logic              horn_out,
  input wire logic              irq_out,
  input wire logic [NUM_IN-1:0] alarm_out,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  req_needs_alarm_a: assert property (alarm_out == '0 |->
    !shutdown_req_out && !loaddump_req_out && !horn_out)
    else $error("request without alarm");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  aw_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  bresp_code_a: assert property (s_axi_bvalid |->
    s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response");

  cover property ($rose(shutdown_req_out));
  cover property ($rose(loaddump_req_out));
  cover property ($rose(horn_out));
  cover property ($rose(irq_out));
endmodule

bind dia_top dia_props #(.NUM_IN(NUM_IN)) i_dia_props (.*);

//--- dia_regs.svh
`ifndef DIA_REGS_SVH
`define DIA_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DIA_CFG_BASE     8'h00
`define DIA_CTRL_OFF     8'h80
`define DIA_ALARM_OFF    8'h84
`define DIA_IRQ_STAT_OFF 8'h88
`define DIA_IRQ_EN_OFF   8'h8C
`define DIA_IRQ_CLR_OFF  8'h90

// ----------------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------------
`define DIA_ACT_LSB   0
`define DIA_SAMP_LSB  2
`define DIA_LATCH_BIT 4
`define DIA_NC_BIT    5
`define DIA_POS_BIT   6
`define DIA_DLY_BIT   7
`define DIA_CFG_W     8

// Control register bits
`define DIA_CTRL_ARST_BIT 0
`define DIA_CTRL_FACT_BIT 1

// ----------------------------------------------------------------------
// Factory configuration words
// ----------------------------------------------------------------------
`define DIA_FACT_IN0 8'h14
`define DIA_FACT_IN1 8'h14
`define DIA_FACT_IN2 8'h00
`define DIA_FACT_IN3 8'h03
`define DIA_FACT_IN4 8'h90
`define DIA_FACT_IN5 8'h02
`define DIA_FACT_IN6 8'h02
`define DIA_FACT_IN7 8'h33
`define DIA_FACT_EXT 8'h03

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DIA_DELAY_MS 4000
`define DIA_CLK_KHZ  200000

// AXI responses
`define DIA_RESP_OKAY   2'h0
`define DIA_RESP_SLVERR 2'h2

`endif

//--- dia_top.sv
`include "dia_regs.svh"

module dia_top
  import dia_pkg::*;
#(
  parameter int          NUM_IN    = 8,
  parameter int unsigned DELAY_CYC = `DIA_DELAY_MS * (`DIA_CLK_KHZ),
  parameter int          ADDR_W    = 8
)(
  input  wire logic              sys_clk_in,
  input  wire logic              rstn_in,
  input  wire logic [NUM_IN-1:0] contact_closed_in,
  input  wire logic [NUM_IN-1:0] batt_pos_in,
  input  wire logic              holdoff_done_in,
  input  wire logic              mains_present_in,
  input  wire logic              alarm_reset_in,
  output logic                   shutdown_req_out,
  output logic                   loaddump_req_out,
  output logic                   horn_out,
  output logic [NUM_IN-1:0]      alarm_out,
  output logic                   irq_out,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam int CFG_W = `DIA_CFG_W;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic [CFG_W-1:0] factory_cfg(input int idx);
    logic [CFG_W-1:0] v;
    v = `DIA_FACT_EXT;
    unique case (idx)
      0: v = `DIA_FACT_IN0;
      1: v = `DIA_FACT_IN1;
      2: v = `DIA_FACT_IN2;
      3: v = `DIA_FACT_IN3;
      4: v = `DIA_FACT_IN4;
      5: v = `DIA_FACT_IN5;
      6: v = `DIA_FACT_IN6;
      7: v = `DIA_FACT_IN7;
      default: v = `DIA_FACT_EXT;
    endcase
    return v;
  endfunction

  // Returns the input index of a configuration address, or -1
  function automatic int cfg_index(input logic [ADDR_W-1:0] a);
    int r;
    r = -1;
    if (a[1:0] == 2'h0 && a < ADDR_W'(`DIA_CTRL_OFF)
        && int'(a[ADDR_W-1:2]) < NUM_IN)
    begin
      r = int'(a[ADDR_W-1:2]);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic              rst_s1_q;
  logic              rst_n;
  logic [NUM_IN-1:0] cc_s1_q;
  logic [NUM_IN-1:0] cc_s2_q;
  logic [NUM_IN-1:0] bp_s1_q;
  logic [NUM_IN-1:0] bp_s2_q;

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cc_s1_q <= '0;
      cc_s2_q <= '0;
      bp_s1_q <= '0;
      bp_s2_q <= '0;
    end
    else
    begin
      cc_s1_q <= contact_closed_in;
      cc_s2_q <= cc_s1_q;
      bp_s1_q <= batt_pos_in;
      bp_s2_q <= bp_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Register storage and bus decode
  // ----------------------------------------------------------------------
  logic [CFG_W-1:0]  cfg_q [NUM_IN];
  logic [NUM_IN-1:0] alarm_q;
  logic [NUM_IN-1:0] alarm_d;
  logic [NUM_IN-1:0] stat_q;
  logic [NUM_IN-1:0] en_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_go;
  logic              wr_ok;
  logic              sw_arst;
  logic              sw_fact;
  logic [NUM_IN-1:0] sw_clr;
  int                wr_idx;

  assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_idx = cfg_index(awaddr_q);
  assign wr_ok  = (wr_idx >= 0) || awaddr_q == ADDR_W'(`DIA_CTRL_OFF)
               || awaddr_q == ADDR_W'(`DIA_IRQ_EN_OFF)
               || awaddr_q == ADDR_W'(`DIA_IRQ_CLR_OFF);
  assign sw_arst = wr_go && wstrb_q[0]
                && awaddr_q == ADDR_W'(`DIA_CTRL_OFF)
                && wdata_q[`DIA_CTRL_ARST_BIT];
  assign sw_fact = wr_go && wstrb_q[0]
                && awaddr_q == ADDR_W'(`DIA_CTRL_OFF)
                && wdata_q[`DIA_CTRL_FACT_BIT];
  assign sw_clr  = (wr_go && awaddr_q == ADDR_W'(`DIA_IRQ_CLR_OFF))
                 ? wdata_q[NUM_IN-1:0] : '0;

  // Write channel: address and data taken in either order
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DIA_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_have_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `DIA_RESP_OKAY : `DIA_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Per-input configuration words; factory restore wins over a write
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_IN; i++)
        cfg_q[i] <= factory_cfg(i);
    end
    else if (sw_fact)
    begin
      for (int i = 0; i < NUM_IN; i++)
        cfg_q[i] <= factory_cfg(i);
    end
    else if (wr_go && wr_idx >= 0 && wstrb_q[0])
    begin
      cfg_q[wr_idx] <= wdata_q[CFG_W-1:0];
    end
  end

  // Interrupt enable, sticky status with set winning over clear
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q    <= '0;
      stat_q  <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      if (wr_go && awaddr_q == ADDR_W'(`DIA_IRQ_EN_OFF))
        en_q <= wdata_q[NUM_IN-1:0];
      stat_q  <= (stat_q & ~sw_clr) | (alarm_d & ~alarm_q);
      irq_out <= |(((stat_q & ~sw_clr) | (alarm_d & ~alarm_q)) & en_q);
    end
  end

  // Read channel
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `DIA_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `DIA_RESP_OKAY;
      s_axi_rdata   <= '0;
      if (cfg_index(s_axi_araddr) >= 0)
        s_axi_rdata[CFG_W-1:0] <= cfg_q[cfg_index(s_axi_araddr)];
      else if (s_axi_araddr == ADDR_W'(`DIA_ALARM_OFF))
        s_axi_rdata[NUM_IN-1:0] <= alarm_q;
      else if (s_axi_araddr == ADDR_W'(`DIA_IRQ_STAT_OFF))
        s_axi_rdata[NUM_IN-1:0] <= stat_q;
      else if (s_axi_araddr == ADDR_W'(`DIA_IRQ_EN_OFF))
        s_axi_rdata[NUM_IN-1:0] <= en_q;
      else if (s_axi_araddr != ADDR_W'(`DIA_CTRL_OFF)
               && s_axi_araddr != ADDR_W'(`DIA_IRQ_CLR_OFF))
        s_axi_rresp <= `DIA_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Per-input conditioning
  // ----------------------------------------------------------------------
  logic [NUM_IN-1:0] is_shut;
  logic [NUM_IN-1:0] is_ldd;
  logic [NUM_IN-1:0] is_warn;

  for (genvar g = 0; g < NUM_IN; g++)
  begin : g_in
    logic [CW-1:0] cnt_q;
    dia_action_t   act;
    dia_sampling_t samp;
    logic          sensed;
    logic          elig;
    logic          live;
    logic          qual;

    assign act  = dia_action_t'(cfg_q[g][`DIA_ACT_LSB +: 2]);
    assign samp = dia_sampling_t'(cfg_q[g][`DIA_SAMP_LSB +: 2]);

    // Polarity must match switching, contact state must match type
    assign sensed = (bp_s2_q[g] == cfg_q[g][`DIA_POS_BIT])
                 && (cc_s2_q[g] ^ cfg_q[g][`DIA_NC_BIT]);

    always_comb
    begin
      unique case (samp)
        DIA_SAMP_ALWAYS:  elig = 1'b1;
        DIA_SAMP_HOLDOFF: elig = holdoff_done_in;
        DIA_SAMP_MAINS:   elig = mains_present_in;
        default:          elig = 1'b0;
      endcase
    end

    // Action 3 never produces an alarm
    assign live = sensed && elig && act != DIA_ACT_NONE;

    // Delay counter restarts on any sample that is not live
    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
      if (!rst_n)
        cnt_q <= '0;
      else if (!live || !cfg_q[g][`DIA_DLY_BIT])
        cnt_q <= '0;
      else if (cnt_q != CW'(DELAY_CYC))
        cnt_q <= cnt_q + CW'(1);
    end

    assign qual = live && (!cfg_q[g][`DIA_DLY_BIT]
                           || cnt_q == CW'(DELAY_CYC));

    // Latched alarms hold until reset; qualifying input wins over reset
    always_comb
    begin
      if (cfg_q[g][`DIA_LATCH_BIT])
        alarm_d[g] = qual || (alarm_q[g]
                     && !(alarm_reset_in || sw_arst));
      else
        alarm_d[g] = qual;
    end

    assign is_shut[g] = alarm_q[g] && act == DIA_ACT_SHUTDOWN;
    assign is_ldd[g]  = alarm_q[g] && act == DIA_ACT_LOADDUMP;
    assign is_warn[g] = alarm_q[g] && act == DIA_ACT_WARNING;
  end

  // ----------------------------------------------------------------------
  // Alarm state and action outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      alarm_q <= '0;
    else
      alarm_q <= alarm_d;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shutdown_req_out <= 1'b0;
      loaddump_req_out <= 1'b0;
      horn_out         <= 1'b0;
      alarm_out        <= '0;
    end
    else
    begin
      shutdown_req_out <= |is_shut;
      loaddump_req_out <= |is_ldd;
      horn_out         <= |is_warn;
      alarm_out        <= alarm_q;
    end
  end

endmodule

//--- dia_top_tb.sv
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t got %h want %h", $time, a, e); end end

module dia_top_tb
  import dia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] cfg; logic c, p, h, m; logic [2:0] e;}
    dia_row_t;
  logic        clk = 0, rstn = 0, hold = 0, mains = 0, arst = 0;
  logic [7:0]  cls = 0, pos = 0, awa = 0, ara = 0, pc, pp, alm;
  logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic        sd, ld, hn, irq, awr, wrd, bv, arr, rv;
  logic [1:0]  br, rr, r;
  logic [31:0] wd = 0, rdat, d;
  int          errors = 0;
  int          tests_run = 0;
  logic [7:0]  fac [5] = '{8'h00, 8'h03, 8'h90, 8'h02, 8'h02};
  dia_row_t    rows [14] = '{
    '{8'h00, 1, 0, 0, 0, 3'h4}, '{8'h01, 1, 0, 0, 0, 3'h2},
    '{8'h02, 1, 0, 0, 0, 3'h1}, '{8'h03, 1, 0, 0, 0, 3'h0},
    '{8'h20, 0, 0, 0, 0, 3'h4}, '{8'h20, 1, 0, 0, 0, 3'h0},
    '{8'h40, 1, 1, 0, 0, 3'h4}, '{8'h40, 1, 0, 0, 0, 3'h0},
    '{8'h00, 1, 1, 0, 0, 3'h0}, '{8'h04, 1, 0, 0, 0, 3'h0},
    '{8'h04, 1, 0, 1, 0, 3'h4}, '{8'h08, 1, 0, 0, 0, 3'h0},
    '{8'h08, 1, 0, 0, 1, 3'h4}, '{8'h0C, 1, 0, 1, 1, 3'h0}};

  always #2.5 clk = ~clk;

  dia_contacts i_dia_contacts (.sys_clk_in(clk), .close_in(cls),
    .pos_in(pos), .contact_closed_out(pc), .batt_pos_out(pp));

  dia_top #(.DELAY_CYC(20)) i_dia_top (.sys_clk_in(clk), .rstn_in(rstn),
    .contact_closed_in(pc), .batt_pos_in(pp), .holdoff_done_in(hold),
    .mains_present_in(mains), .alarm_reset_in(arst),
    .shutdown_req_out(sd), .loaddump_req_out(ld), .horn_out(hn),
    .alarm_out(alm), .irq_out(irq), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre));

  task automatic summarize;
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Handshakes are judged at the falling edge, acted on at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    hb = 0;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    for (int n = 0; !hb; n++)
    begin
      @(negedge clk);
      ha = awv && awr === 1'b1;
      hw = wv && wrd === 1'b1;
      hb = bv === 1'b1 && bre;
      r = br;
      @(posedge clk);
      if (ha) awv <= 0;
      if (hw) wv <= 0;
      if (n > 200) begin errors++; summarize(); end
    end
    bre <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    hr = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rre <= 1;
    for (int n = 0; !hr; n++)
    begin
      @(negedge clk);
      ha = arv && arr === 1'b1;
      hr = rv === 1'b1 && rre;
      d = rdat;
      r = rr;
      @(posedge clk);
      if (ha) arv <= 0;
      if (n > 200) begin errors++; summarize(); end
    end
    rre <= 0;
  endtask

  initial
  begin
    tick(16);
    rstn <= 1;
    tick(6);
    // Factory words and register map edges
    for (int i = 2; i < 7; i++)
    begin
      rd(8'(4 * i));
      `CHK(d[7:0], fac[i-2]);
    end
    rd(8'h1C);
    `CHK(r, 2'h0);
    rd(8'hFC);
    `CHK({r, d}, {2'h2, 32'h0000_0000});
    $display("reset test done");
    // Configuration table on input 0
    foreach (rows[i])
    begin
      wr(8'h00, 32'(rows[i].cfg));
      cls[0] <= rows[i].c;
      pos[0] <= rows[i].p;
      hold <= rows[i].h;
      mains <= rows[i].m;
      tick(6);
      @(negedge clk);
      `CHK({sd, ld, hn}, rows[i].e);
      `CHK(alm[0], |rows[i].e);
      wr(8'h00, 32'h0000_0003);
      {cls[0], pos[0], hold, mains} <= 4'h0;
      tick(6);
    end
    $display("table test done");
    // Delayed latched input 4 with a gap in the delay
    cls[4] <= 1;
    tick(15);
    cls[4] <= 0;
    tick(3);
    cls[4] <= 1;
    tick(18);
    @(negedge clk);
    `CHK({alm[4], sd}, 2'h0);
    tick(10);
    @(negedge clk);
    `CHK({alm[4], sd, irq}, 3'h6);
    wr(8'h8C, 32'h0000_0010);
    `CHK(r, 2'h0);
    tick(2);
    @(negedge clk);
    `CHK(irq, 1'h1);
    rd(8'h88);
    `CHK(d[4], 1'h1);
    cls[4] <= 0;
    tick(8);
    `CHK({alm[4], sd}, 2'h3);
    arst <= 1;
    tick(1);
    arst <= 0;
    tick(6);
    @(negedge clk);
    `CHK({alm[4], sd}, 2'h0);
    wr(8'h90, 32'h0000_0010);
    tick(2);
    @(negedge clk);
    `CHK(irq, 1'h0);
    $display("delay test done");
    // Read-only write and factory restore
    wr(8'h84, 32'h0000_00FF);
    `CHK(r, 2'h2);
    wr(8'h08, 32'h0000_0002);
    wr(8'h80, 32'h0000_0002);
    rd(8'h08);
    `CHK(d[7:0], 8'h00);
    // Latch input 4 again and clear it through the control register
    cls[4] <= 1;
    tick(30);
    cls[4] <= 0;
    tick(6);
    @(negedge clk);
    `CHK({alm[4], sd}, 2'h3);
    wr(8'h80, 32'h0000_0001);
    `CHK(r, 2'h0);
    tick(3);
    @(negedge clk);
    `CHK({alm[4], sd}, 2'h0);
    $display("restore test done");
    // Mid-run reset drops alarms and reloads factory words
    wr(8'h08, 32'h0000_0002);
    cls[5] <= 1;
    tick(8);
    @(negedge clk);
    `CHK({hn, alm[5]}, 2'h3);
    tick(1);
    rstn <= 0;
    tick(2);
    @(negedge clk);
    `CHK({sd, ld, hn, irq, alm}, 12'h000);
    tick(1);
    rstn <= 1;
    tick(6);
    rd(8'h08);
    `CHK(d[7:0], 8'h00);
    @(negedge clk);
    `CHK({hn, alm[5]}, 2'h3);
    $display("reset again test done");
    summarize();
  end
endmodule
